// >>> src/nce_pkg.sv
package nce_pkg;

  localparam int unsigned PC_W        = 12;
  localparam logic [3:0]  BANK0       = 4'h0;
  localparam logic [7:0]  SP_LO_ADDR  = 8'h7e;
  localparam logic [7:0]  SP_HI_ADDR  = 8'h7f;
  localparam logic [7:0]  MI_ADDR     = 8'h7c;
  localparam int unsigned MI_BIT      = 0;
  localparam logic [7:0]  SP_RST      = 8'h81;
  localparam int unsigned TBL_LSB     = 8;
  localparam logic [3:0]  REG_RST     = 4'h0;
  localparam logic [11:0] PC_RST      = 12'h000;

  typedef enum logic [4:0] {
    set_bank_common_op           = 5'b00000,
    set_bank_enable_op           = 5'b00001,
    set_carry_op                 = 5'b00010,
    memory_bit_set_op            = 5'b00011,
    direct_bit_set_op            = 5'b00100,
    subtract_with_borrow_op      = 5'b00101,
    byte_subtract_with_borrow_op = 5'b00110,
    subtract_borrow_skip_op      = 5'b00111,
    subtract_skip_op             = 5'b01000,
    byte_subtract_skip_op        = 5'b01001,
    acc_bit_test_op              = 5'b01010,
    carry_test_op                = 5'b01011,
    memory_bit_test_op           = 5'b01100,
    direct_bit_test_op           = 5'b01101,
    swap_acc_b_op                = 5'b01110,
    acc_memory_swap_op           = 5'b01111,
    pair_memory_swap_op          = 5'b10000,
    direct_nibble_swap_op        = 5'b10001,
    direct_byte_swap_op          = 5'b10010,
    swap_and_flip_high_op        = 5'b10011,
    swap_post_increment_op       = 5'b10100,
    swap_post_decrement_op       = 5'b10101
  } nce_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } nce_state_t;

  function automatic logic has_xy_form(input nce_op_t op);
    case (op)
      memory_bit_set_op, subtract_with_borrow_op, byte_subtract_with_borrow_op,
      subtract_borrow_skip_op, subtract_skip_op, byte_subtract_skip_op,
      memory_bit_test_op, acc_memory_swap_op, pair_memory_swap_op: has_xy_form = 1'b1;
      default: has_xy_form = 1'b0;
    endcase
  endfunction : has_xy_form

  function automatic logic is_direct(input nce_op_t op);
    case (op)
      direct_bit_set_op, direct_bit_test_op, direct_nibble_swap_op,
      direct_byte_swap_op: is_direct = 1'b1;
      default: is_direct = 1'b0;
    endcase
  endfunction : is_direct

  function automatic logic is_byte(input nce_op_t op);
    case (op)
      byte_subtract_with_borrow_op, byte_subtract_skip_op, pair_memory_swap_op,
      direct_byte_swap_op: is_byte = 1'b1;
      default: is_byte = 1'b0;
    endcase
  endfunction : is_byte

  function automatic logic [1:0] op_cycles(input nce_op_t op, input logic xy);
    logic [1:0] base;
    case (op)
      direct_bit_set_op, byte_subtract_with_borrow_op, byte_subtract_skip_op,
      direct_bit_test_op, swap_acc_b_op, pair_memory_swap_op, direct_nibble_swap_op,
      direct_byte_swap_op, swap_post_increment_op, swap_post_decrement_op: base = 2'h2;
      default: base = 2'h1;
    endcase
    op_cycles = base + {1'b0, xy};
  endfunction : op_cycles

  function automatic logic [1:0] op_bytes(input nce_op_t op, input logic xy);
    op_bytes = (is_direct(op) ? 2'h2 : 2'h1) + {1'b0, xy};
  endfunction : op_bytes

  function automatic logic [1:0] op_accesses(input nce_op_t op);
    case (op)
      set_bank_common_op, set_bank_enable_op, set_carry_op, acc_bit_test_op,
      carry_test_op, swap_acc_b_op: op_accesses = 2'h0;
      default: op_accesses = is_byte(op) ? 2'h2 : 2'h1;
    endcase
  endfunction : op_accesses

  function automatic logic [3:0] bit_mask(input logic [1:0] sel);
    bit_mask = 4'h1 << sel;
  endfunction : bit_mask

  function automatic logic [7:0] stack_lo_addr(input logic [7:0] sp);
    stack_lo_addr = sp - 8'h01;
  endfunction : stack_lo_addr

endpackage : nce_pkg

// >>> src/nce_sub4.sv
`timescale 1ns/1ps
module nce_sub4 (
  input  wire logic [3:0] a_i,     // Minuend nibble
  input  wire logic [3:0] m_i,     // Subtrahend nibble
  input  wire logic       bin_i,   // Borrow in
  output logic      [3:0] d_o,     // Difference
  output logic            bout_o   // Borrow out
);
  logic [4:0] wide;

  // The fifth bit of the widened difference is the borrow.
  assign wide   = {1'b0, a_i} - {1'b0, m_i} - {4'h0, bin_i};
  assign d_o    = wide[3:0];
  assign bout_o = wide[4];
endmodule : nce_sub4

// >>> src/nce_exec_top.sv
`timescale 1ns/1ps
module nce_exec_top (
  input  wire logic              sys_clk_i,     // 10 MHz clock
  input  wire logic              arst_n_i,      // Asynchronous reset, active low
  input  wire logic              start_i,       // Issue op, taken when idle
  input  wire nce_pkg::nce_op_t  op_i,          // Operation to issue
  input  wire logic              xy_form_i,     // Secondary pointer form
  input  wire logic [1:0]        bit_sel_i,     // Two-bit immediate
  input  wire logic [7:0]        imm8_i,        // Direct low address
  input  wire logic [3:0]        bank_i,        // Data memory bank for access
  input  wire logic              ld_i,          // Load working register, idle only
  input  wire logic [2:0]        ld_sel_i,      // 0 A,1 B,2 H,3 L,4 X,5 Y,6 C
  input  wire logic [3:0]        ld_val_i,      // Load value
  input  wire logic              pc_load_i,     // Load program counter
  input  wire logic [11:0]       pc_val_i,      // Program counter value
  input  wire logic              tbl_load_i,    // Form table address
  input  wire logic [3:0]        tbl_page_i,    // Table page immediate
  input  wire logic [3:0]        mem_rdata_i,   // Data memory read, asynchronous
  output logic      [11:0]       mem_addr_o,    // Bank and nibble address
  output logic                   mem_wr_o,      // Write strobe
  output logic      [3:0]        mem_wdata_o,   // Write nibble
  output logic      [3:0]        acc_o,         // Accumulator
  output logic      [3:0]        b_o,           // B register
  output logic      [7:0]        hl_o,          // Primary pointer pair
  output logic      [7:0]        xy_o,          // Secondary pointer pair
  output logic                   carry_o,       // Carry flag
  output logic                   bcf_o,         // Bank common flag
  output logic                   bef_o,         // Bank enable flag
  output logic                   mie_o,         // Master interrupt enable
  output logic      [7:0]        sp_o,          // Stack pointer mirror
  output logic      [7:0]        stack_lo_o,    // Stack byte low nibble address
  output logic      [11:0]       pc_o,          // Program counter
  output logic      [11:0]       tbl_addr_o,    // Table address
  output logic                   busy_o,        // Op in progress
  output logic                   done_o,        // Op finished, one cycle
  output logic                   skipped_o,     // Finished op was skipped
  output logic                   skip_pend_o    // Next op will be skipped
);

  typedef struct packed {
    nce_pkg::nce_state_t st;
    logic                ph;
    logic [1:0]          mc;
    logic [1:0]          ncyc;
    logic [1:0]          nacc;
    nce_pkg::nce_op_t    op;
    logic                xy;
    logic [1:0]          bsel;
    logic                squash;
    logic                skip_pend;
    logic                bor;
    logic [3:0]          a;
    logic [3:0]          b;
    logic [3:0]          h;
    logic [3:0]          l;
    logic [3:0]          x;
    logic [3:0]          y;
    logic                c;
    logic                bcf;
    logic                bef;
    logic                mi;
    logic [7:0]          sp;
    logic [7:0]          stk_lo;
    logic [11:0]         pc;
    logic [11:0]         tbl;
    logic [11:0]         addr;
    logic                wr;
    logic [3:0]          wdata;
    logic                done;
    logic                skipped;
  } nce_core_t;

  nce_core_t s_q;
  nce_core_t s_d;

  logic [1:0] lead;
  logic       act;
  logic       hi_nib;
  logic       byte_op;
  logic [3:0] alu_a;
  logic       alu_bin;
  logic [3:0] alu_d;
  logic       alu_bout;
  logic [3:0] mask;

  // Accesses sit at the end of the op, so secondary forms lead with an idle cycle.
  assign byte_op = nce_pkg::is_byte(s_q.op);
  assign lead    = s_q.ncyc - ((s_q.nacc == 2'h0) ? 2'h1 : s_q.nacc);
  assign act     = (s_q.st == nce_pkg::ST_RUN) && !s_q.ph && (s_q.mc >= lead);
  assign hi_nib  = byte_op && s_q.addr[0];
  assign mask    = nce_pkg::bit_mask(s_q.bsel);

  always_comb
  begin
    alu_a   = hi_nib ? s_q.b : s_q.a;
    alu_bin = 1'b0;
    case (s_q.op)
      nce_pkg::subtract_with_borrow_op, nce_pkg::subtract_borrow_skip_op:
        alu_bin = s_q.c;
      nce_pkg::byte_subtract_with_borrow_op:
        alu_bin = hi_nib ? s_q.bor : s_q.c;
      nce_pkg::byte_subtract_skip_op:
        alu_bin = hi_nib ? s_q.bor : 1'b0;
      default:
        alu_bin = 1'b0;
    endcase
  end

  nce_sub4 u_sub (
    .a_i    (alu_a),
    .m_i    (mem_rdata_i),
    .bin_i  (alu_bin),
    .d_o    (alu_d),
    .bout_o (alu_bout)
  );

  always_comb
  begin
    logic [7:0] ea;
    logic       skip;
    logic [3:0] nl;
    ea   = 8'h00;
    skip = 1'b0;
    nl   = 4'h0;
    s_d  = s_q;
    s_d.done    = 1'b0;
    s_d.skipped = 1'b0;
    s_d.wr      = 1'b0;
    // Stack pointer and interrupt enable live in memory; the core mirrors each write.
    if (s_q.wr && (s_q.addr[11:8] == nce_pkg::BANK0))
    begin
      if (s_q.addr[7:0] == nce_pkg::SP_LO_ADDR)
      begin
        s_d.sp[3:0]  = s_q.wdata | 4'h1;
      end
      else if (s_q.addr[7:0] == nce_pkg::SP_HI_ADDR)
      begin
        s_d.sp[7:4]  = s_q.wdata | 4'h8;
      end
      else if (s_q.addr[7:0] == nce_pkg::MI_ADDR)
      begin
        s_d.mi = s_q.wdata[nce_pkg::MI_BIT];
      end
    end
    s_d.stk_lo = nce_pkg::stack_lo_addr(s_d.sp);
    case (s_q.st)
      nce_pkg::ST_IDLE:
      begin
        if (ld_i)
        begin
          case (ld_sel_i)
            3'h0: s_d.a = ld_val_i;
            3'h1: s_d.b = ld_val_i;
            3'h2: s_d.h = ld_val_i;
            3'h3: s_d.l = ld_val_i;
            3'h4: s_d.x = ld_val_i;
            3'h5: s_d.y = ld_val_i;
            3'h6: s_d.c = ld_val_i[0];
            default: s_d.c = s_q.c;
          endcase
        end
        if (pc_load_i)
        begin
          s_d.pc = pc_val_i;
        end
        if (tbl_load_i)
        begin
          s_d.tbl = {tbl_page_i, s_q.x, s_q.y};
        end
        if (start_i)
        begin
          s_d.op   = op_i;
          s_d.xy   = xy_form_i && nce_pkg::has_xy_form(op_i);
          s_d.bsel = bit_sel_i;
          if (nce_pkg::is_direct(op_i))
          begin
            ea = imm8_i;
          end
          else if (s_d.xy)
          begin
            ea = {s_q.x, s_q.y};
          end
          else
          begin
            ea = {s_q.h, s_q.l};
          end
          if (nce_pkg::is_byte(op_i))
          begin
            ea[0] = 1'b0;
          end
          s_d.ncyc      = nce_pkg::op_cycles(op_i, s_d.xy);
          s_d.nacc      = nce_pkg::op_accesses(op_i);
          s_d.mc        = 2'h0;
          s_d.ph        = 1'b0;
          s_d.squash    = s_q.skip_pend;
          s_d.skip_pend = 1'b0;
          s_d.bor       = 1'b0;
          s_d.addr      = {bank_i, ea};
          s_d.st        = nce_pkg::ST_RUN;
        end
      end
      nce_pkg::ST_RUN:
      begin
        if (!s_q.ph)
        begin
          s_d.ph = 1'b1;
          if (act && !s_q.squash)
          begin
            case (s_q.op)
              nce_pkg::set_bank_common_op: s_d.bcf = 1'b1;
              nce_pkg::set_bank_enable_op: s_d.bef = 1'b1;
              nce_pkg::set_carry_op:       s_d.c   = 1'b1;
              nce_pkg::memory_bit_set_op, nce_pkg::direct_bit_set_op:
              begin
                s_d.wr    = 1'b1;
                s_d.wdata = mem_rdata_i | mask;
              end
              nce_pkg::subtract_with_borrow_op:
              begin
                s_d.a = alu_d;
                s_d.c = alu_bout;
              end
              nce_pkg::subtract_borrow_skip_op:
              begin
                s_d.a = alu_d;
                s_d.c = alu_bout;
                skip  = !alu_bout;
              end
              nce_pkg::subtract_skip_op:
              begin
                s_d.a = alu_d;
                skip  = alu_bout;
              end
              nce_pkg::byte_subtract_with_borrow_op, nce_pkg::byte_subtract_skip_op:
              begin
                s_d.bor = alu_bout;
                if (hi_nib)
                begin
                  s_d.b = alu_d;
                  if (s_q.op == nce_pkg::byte_subtract_skip_op)
                  begin
                    skip = alu_bout;
                  end
                  else
                  begin
                    s_d.c = alu_bout;
                  end
                end
                else
                begin
                  s_d.a = alu_d;
                end
              end
              nce_pkg::acc_bit_test_op:    skip = |(s_q.a & mask);
              nce_pkg::carry_test_op:      skip = s_q.c;
              nce_pkg::memory_bit_test_op, nce_pkg::direct_bit_test_op:
                skip = |(mem_rdata_i & mask);
              nce_pkg::swap_acc_b_op:
              begin
                s_d.a = s_q.b;
                s_d.b = s_q.a;
              end
              nce_pkg::pair_memory_swap_op, nce_pkg::direct_byte_swap_op:
              begin
                s_d.wr = 1'b1;
                if (hi_nib)
                begin
                  s_d.wdata = s_q.b;
                  s_d.b     = mem_rdata_i;
                end
                else
                begin
                  s_d.wdata = s_q.a;
                  s_d.a     = mem_rdata_i;
                end
              end
              default:
              begin
                // Nibble swaps with the accumulator, plus their pointer side effects.
                s_d.wr    = 1'b1;
                s_d.wdata = s_q.a;
                s_d.a     = mem_rdata_i;
                if (s_q.op == nce_pkg::swap_and_flip_high_op)
                begin
                  s_d.h = s_q.h ^ {2'b00, s_q.bsel};
                end
                else if (s_q.op == nce_pkg::swap_post_increment_op)
                begin
                  nl    = s_q.l + 4'h1;
                  s_d.l = nl;
                  skip  = (nl == 4'h0);
                end
                else if (s_q.op == nce_pkg::swap_post_decrement_op)
                begin
                  nl    = s_q.l - 4'h1;
                  s_d.l = nl;
                  skip  = (nl == 4'hf);
                end
              end
            endcase
            if (skip)
            begin
              s_d.skip_pend = 1'b1;
            end
          end
        end
        else
        begin
          s_d.ph = 1'b0;
          if (s_q.mc == s_q.ncyc - 2'h1)
          begin
            s_d.done    = 1'b1;
            s_d.skipped = s_q.squash;
            s_d.squash  = 1'b0;
            s_d.pc      = s_q.pc + {10'h000, nce_pkg::op_bytes(s_q.op, s_q.xy)};
            s_d.st      = nce_pkg::ST_IDLE;
          end
          else
          begin
            s_d.mc = s_q.mc + 2'h1;
            if (byte_op && (s_q.mc >= lead))
            begin
              s_d.addr[0] = 1'b1;
            end
          end
        end
      end
      default:
      begin
        s_d.st = nce_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_q           <= '0;
      s_q.st        <= nce_pkg::ST_IDLE;
      s_q.op        <= nce_pkg::set_bank_common_op;
      s_q.a         <= nce_pkg::REG_RST;
      s_q.b         <= nce_pkg::REG_RST;
      s_q.sp        <= nce_pkg::SP_RST;
      s_q.stk_lo    <= nce_pkg::SP_RST - 8'h01;
      s_q.pc        <= nce_pkg::PC_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign mem_addr_o  = s_q.addr;
  assign mem_wr_o    = s_q.wr;
  assign mem_wdata_o = s_q.wdata;
  assign acc_o       = s_q.a;
  assign b_o         = s_q.b;
  assign hl_o        = {s_q.h, s_q.l};
  assign xy_o        = {s_q.x, s_q.y};
  assign carry_o     = s_q.c;
  assign bcf_o       = s_q.bcf;
  assign bef_o       = s_q.bef;
  assign mie_o       = s_q.mi;
  assign sp_o        = s_q.sp;
  assign stack_lo_o  = s_q.stk_lo;
  assign pc_o        = s_q.pc;
  assign tbl_addr_o  = s_q.tbl;
  assign busy_o      = (s_q.st == nce_pkg::ST_RUN);
  assign done_o      = s_q.done;
  assign skipped_o   = s_q.skipped;
  assign skip_pend_o = s_q.skip_pend;

endmodule : nce_exec_top

// >>> tb/nce_mem_model.sv
`timescale 1ns/1ps
module nce_mem_model (
  input  wire logic        clk_i,   // Clock
  input  wire logic [11:0] addr_i,  // Bank and nibble address
  input  wire logic        wr_i,    // Write strobe
  input  wire logic [3:0]  wdata_i, // Write nibble
  output logic      [3:0]  rdata_o  // Read nibble, asynchronous
);
  logic [3:0] mem [0:4095];

  initial
  begin
    for (int i = 0; i < 4096; i++) mem[i] = 4'h0;
  end

  // The read is combinational because the core samples it in the same cycle.
  assign rdata_o = mem[addr_i];

  // A plain always is used because the bench also preloads words of this array.
  always @(posedge clk_i)
  begin
    if (wr_i) mem[addr_i] <= wdata_i;
  end
endmodule : nce_mem_model

// >>> tb/nce_exec_top_assertions.sv
`timescale 1ns/1ps
module nce_exec_top_assertions (
  input wire logic             sys_clk_i,   // Clock
  input wire logic             arst_n_i,    // Reset
  input wire logic             start_i,     // Issue
  input wire nce_pkg::nce_op_t op_i,        // Operation
  input wire logic             xy_form_i,   // Secondary form
  input wire logic [1:0]       bit_sel_i,   // Bit select
  input wire logic [3:0]       mem_rdata_i, // Read data
  input wire logic [11:0]      mem_addr_o,  // Address
  input wire logic             mem_wr_o,    // Write strobe
  input wire logic [3:0]       mem_wdata_o, // Write data
  input wire logic [7:0]       hl_o,        // Primary pair
  input wire logic             carry_o,     // Carry
  input wire logic             mie_o,       // Interrupt enable
  input wire logic [7:0]       sp_o,        // Stack pointer
  input wire logic [7:0]       stack_lo_o,  // Stack low address
  input wire logic             busy_o,      // Busy
  input wire logic             done_o,      // Done
  input wire logic             skipped_o,   // Skipped
  input wire logic             skip_pend_o  // Skip pending
);
  nce_pkg::nce_op_t op_q;
  logic [1:0]       sel_q;
  logic             xy_q;
  logic             sk_q;
  logic             st_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  // Remember what was taken, since op_i may change while the op runs.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      op_q  <= nce_pkg::set_carry_op;
      sel_q <= 2'h0;
      xy_q  <= 1'b0;
      sk_q  <= 1'b0;
      st_q  <= 1'b0;
    end
    else
    begin
      st_q <= start_i && !busy_o;
      if (start_i && !busy_o)
      begin
        op_q  <= op_i;
        sel_q <= bit_sel_i;
        xy_q  <= xy_form_i;
        sk_q  <= skip_pend_o;
      end
    end
  end

  flag_set_a: assert property (start_i && !busy_o && !skip_pend_o &&
    op_i == nce_pkg::set_carry_op |-> ##3 done_o && carry_o) else $error("carry not set");
  bit_set_a: assert property (mem_wr_o && op_q == nce_pkg::memory_bit_set_op && !sk_q
    |-> mem_wdata_o == ($past(mem_rdata_i) | (4'h1 << sel_q))) else $error("bit set wrong");
  hl_addr_a: assert property (st_q && op_q == nce_pkg::acc_memory_swap_op && !xy_q
    |-> mem_addr_o[7:0] == $past(hl_o)) else $error("pointer address wrong");
  byte_order_a: assert property (st_q && op_q == nce_pkg::direct_byte_swap_op && !sk_q
    |-> !mem_addr_o[0] ##2 mem_addr_o[0]) else $error("byte nibble order wrong");
  skip_quiet_a: assert property (busy_o && sk_q |-> !mem_wr_o) else $error("skipped op wrote");
  carry_skip_a: assert property (done_o && !skipped_o && op_q == nce_pkg::carry_test_op
    |-> skip_pend_o == carry_o) else $error("carry test skip wrong");
  mie_track_a: assert property (mem_wr_o && mem_addr_o == 12'h07c
    |=> mie_o == $past(mem_wdata_o[0])) else $error("interrupt enable not tracked");
  sp_shape_a: assert property (sp_o[7] && sp_o[0] && stack_lo_o == sp_o - 8'h01)
    else $error("stack pointer shape wrong");

  cover property (done_o && skipped_o);
  cover property (st_q && op_q == nce_pkg::direct_byte_swap_op);
  cover property (done_o && skip_pend_o && op_q == nce_pkg::carry_test_op);
endmodule : nce_exec_top_assertions

bind nce_exec_top nce_exec_top_assertions i_chk (.sys_clk_i, .arst_n_i, .start_i, .op_i,
  .xy_form_i, .bit_sel_i, .mem_rdata_i, .mem_addr_o, .mem_wr_o, .mem_wdata_o, .hl_o,
  .carry_o, .mie_o, .sp_o, .stack_lo_o, .busy_o, .done_o, .skipped_o, .skip_pend_o);

// >>> tb/nce_exec_top_tb_top.sv
`timescale 1ns/1ps
module nce_exec_top_tb_top;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic start_i = 1'b0;
  nce_pkg::nce_op_t op_i = nce_pkg::set_carry_op;
  logic xy_form_i = 1'b0;
  logic [1:0] bit_sel_i = 2'h0;
  logic [7:0] imm8_i = 8'h00;
  logic [3:0] bank_i = 4'h0;
  logic ld_i = 1'b0;
  logic [2:0] ld_sel_i = 3'h7;
  logic [3:0] ld_val_i = 4'h0;
  logic pc_load_i = 1'b0;
  logic [11:0] pc_val_i = 12'h000;
  logic tbl_load_i = 1'b0;
  logic [3:0] tbl_page_i = 4'h0;
  logic [3:0] mem_rdata_i, mem_wdata_o, acc_o, b_o;
  logic [11:0] mem_addr_o, pc_o, tbl_addr_o;
  logic [7:0] hl_o, xy_o, sp_o, stack_lo_o;
  logic mem_wr_o, carry_o, bcf_o, bef_o, mie_o, busy_o, done_o, skipped_o, skip_pend_o;
  int failures = 0;
  int checks_done = 0;
  logic [11:0] cycles_taken = 12'h000;

  nce_exec_top i_dut (.sys_clk_i, .arst_n_i, .start_i, .op_i, .xy_form_i, .bit_sel_i,
    .imm8_i, .bank_i, .ld_i, .ld_sel_i, .ld_val_i, .pc_load_i, .pc_val_i, .tbl_load_i,
    .tbl_page_i, .mem_rdata_i, .mem_addr_o, .mem_wr_o, .mem_wdata_o, .acc_o, .b_o, .hl_o,
    .xy_o, .carry_o, .bcf_o, .bef_o, .mie_o, .sp_o, .stack_lo_o, .pc_o, .tbl_addr_o,
    .busy_o, .done_o, .skipped_o, .skip_pend_o);
  nce_mem_model i_mem (.clk_i(sys_clk_i), .addr_i(mem_addr_o), .wr_i(mem_wr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  initial
  begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ld(input logic [2:0] s, input logic [3:0] v);
    @(negedge sys_clk_i);
    ld_i = 1'b1;
    ld_sel_i = s;
    ld_val_i = v;
    @(negedge sys_clk_i);
    ld_i = 1'b0;
  endtask : ld

  // Returns in the cycle where done is high, so pulse outputs can be read.
  task automatic run(input nce_pkg::nce_op_t o, input logic x = 1'b0,
                     input logic [1:0] s = 2'h0, input logic [7:0] m = 8'h00);
    int n;
    @(negedge sys_clk_i);
    op_i = o;
    xy_form_i = x;
    bit_sel_i = s;
    imm8_i = m;
    start_i = 1'b1;
    @(negedge sys_clk_i);
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(n < 20, 12'h001);
    cycles_taken = n[11:0];
    chk(busy_o, 12'h000);
  endtask : run

  // Skip flag is consumed by a harmless op so later scenarios start clean.
  task automatic tst(input nce_pkg::nce_op_t o, input logic [1:0] s, input logic [7:0] m,
                     input logic exp);
    run(o, 1'b0, s, m);
    chk(skip_pend_o, exp);
    run(nce_pkg::set_bank_common_op);
  endtask : tst

  task automatic t_flags;
    run(nce_pkg::set_bank_common_op);
    chk(bcf_o, 12'h001);
    run(nce_pkg::set_bank_enable_op);
    chk(bef_o, 12'h001);
    run(nce_pkg::set_carry_op);
    chk(carry_o, 12'h001);
    chk(cycles_taken, 12'h002);
  endtask : t_flags

  task automatic t_bitset;
    ld(3'h2, 4'h2);
    ld(3'h3, 4'h4);
    for (int s = 0; s < 4; s++)
    begin
      run(nce_pkg::memory_bit_set_op, 1'b0, s[1:0]);
      chk(i_mem.mem[12'h024], (12'h002 << s) - 12'h001);
    end
    ld(3'h4, 4'h3);
    ld(3'h5, 4'h1);
    i_mem.mem[12'h031] = 4'h8;
    run(nce_pkg::memory_bit_set_op, 1'b1, 2'h0);
    chk(i_mem.mem[12'h031], 12'h009);
    run(nce_pkg::direct_bit_set_op, 1'b0, 2'h3, 8'h40);
    chk(i_mem.mem[12'h040], 12'h008);
  endtask : t_bitset

  task automatic t_sub;
    ld(3'h0, 4'h3);
    i_mem.mem[12'h024] = 4'h5;
    run(nce_pkg::subtract_with_borrow_op);
    chk({carry_o, acc_o}, 12'h01d);
    run(nce_pkg::subtract_borrow_skip_op);
    chk({skip_pend_o, carry_o, acc_o}, 12'h027);
    run(nce_pkg::set_carry_op);
    chk({skipped_o, carry_o}, 12'h002);
    i_mem.mem[12'h024] = 4'h9;
    run(nce_pkg::subtract_skip_op);
    chk({skip_pend_o, carry_o, acc_o}, 12'h02e);
    run(nce_pkg::set_carry_op);
    ld(3'h1, 4'h1);
    ld(3'h0, 4'h0);
    i_mem.mem[12'h024] = 4'h1;
    i_mem.mem[12'h025] = 4'h2;
    run(nce_pkg::byte_subtract_skip_op);
    chk({skip_pend_o, b_o, acc_o}, 12'h1ef);
    run(nce_pkg::set_carry_op);
    chk(carry_o, 12'h000);
  endtask : t_sub

  task automatic t_tests;
    ld(3'h0, 4'h4);
    tst(nce_pkg::acc_bit_test_op, 2'h2, 8'h00, 1'b1);
    tst(nce_pkg::acc_bit_test_op, 2'h1, 8'h00, 1'b0);
    tst(nce_pkg::carry_test_op, 2'h0, 8'h00, 1'b0);
    run(nce_pkg::set_carry_op);
    tst(nce_pkg::carry_test_op, 2'h0, 8'h00, 1'b1);
    tst(nce_pkg::memory_bit_test_op, 2'h0, 8'h00, 1'b1);
    tst(nce_pkg::memory_bit_test_op, 2'h1, 8'h00, 1'b0);
    tst(nce_pkg::direct_bit_test_op, 2'h3, 8'h40, 1'b1);
  endtask : t_tests

  task automatic t_swaps;
    i_mem.mem[12'h050] = 4'h3;
    i_mem.mem[12'h051] = 4'h9;
    ld(3'h1, 4'h1);
    ld(3'h0, 4'h2);
    run(nce_pkg::direct_byte_swap_op, 1'b0, 2'h0, 8'h51);
    chk({b_o, acc_o}, 12'h093);
    chk({i_mem.mem[12'h051], i_mem.mem[12'h050]}, 12'h012);
    ld(3'h2, 4'h5);
    run(nce_pkg::swap_and_flip_high_op, 1'b0, 2'h3);
    chk(hl_o, 12'h064);
    ld(3'h3, 4'hf);
    tst(nce_pkg::swap_post_increment_op, 2'h0, 8'h00, 1'b1);
    chk(hl_o, 12'h060);
    tst(nce_pkg::swap_post_decrement_op, 2'h0, 8'h00, 1'b1);
    chk(hl_o, 12'h06f);
  endtask : t_swaps

  task automatic t_pairs;
    ld(3'h2, 4'h3);
    ld(3'h3, 4'h6);
    ld(3'h1, 4'h2);
    ld(3'h0, 4'h5);
    ld(3'h6, 4'h1);
    i_mem.mem[12'h036] = 4'h6;
    i_mem.mem[12'h037] = 4'h1;
    run(nce_pkg::byte_subtract_with_borrow_op);
    chk({carry_o, b_o, acc_o}, 12'h00e);
    run(nce_pkg::acc_memory_swap_op);
    chk({acc_o, i_mem.mem[12'h036]}, 12'h06e);
    ld(3'h4, 4'h3);
    ld(3'h5, 4'h7);
    run(nce_pkg::pair_memory_swap_op, 1'b1);
    chk({b_o, acc_o, i_mem.mem[12'h037]}, 12'h1e0);
    chk(cycles_taken, 12'h006);
    run(nce_pkg::swap_acc_b_op);
    chk({b_o, acc_o}, 12'h0e1);
  endtask : t_pairs

  task automatic t_stack;
    chk(sp_o, 12'h081);
    chk(stack_lo_o, 12'h080);
    ld(3'h0, 4'h4);
    run(nce_pkg::direct_nibble_swap_op, 1'b0, 2'h0, 8'h7e);
    chk(sp_o, 12'h085);
    chk(stack_lo_o, 12'h084);
    ld(3'h0, 4'h1);
    run(nce_pkg::direct_nibble_swap_op, 1'b0, 2'h0, 8'h7c);
    chk(mie_o, 12'h001);
  endtask : t_stack

  task automatic t_pc;
    @(negedge sys_clk_i);
    pc_load_i = 1'b1;
    pc_val_i = 12'h100;
    @(negedge sys_clk_i);
    pc_load_i = 1'b0;
    run(nce_pkg::set_carry_op);
    chk(pc_o, 12'h101);
    run(nce_pkg::direct_bit_set_op, 1'b0, 2'h0, 8'h40);
    chk(pc_o, 12'h103);
    ld(3'h4, 4'ha);
    ld(3'h5, 4'hb);
    chk(xy_o, 12'h0ab);
    @(negedge sys_clk_i);
    tbl_load_i = 1'b1;
    tbl_page_i = 4'h3;
    @(negedge sys_clk_i);
    tbl_load_i = 1'b0;
    @(negedge sys_clk_i);
    chk(tbl_addr_o, 12'h3ab);
  endtask : t_pc

  // The whole sequence needs well under 1000 cycles.
  initial
  begin
    #500000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  initial
  begin
    repeat (3) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    t_stack();
    t_flags();
    t_bitset();
    t_sub();
    t_tests();
    t_swaps();
    t_pairs();
    t_pc();
    conclude();
  end
endmodule : nce_exec_top_tb_top
